// [gpf_pkg.sv]
// Constants and types for the general-purpose pin function control block
// Summary of operation
// - Report mode makes status bit carry alert
// - Busy select: pin zero or pin three
// - Alert select: pin zero or pin two
// - Lane code 0 single, 1 dual
// - All-ones lane code gives single lane
// - Package code: quad on wafer, else single
// - Busy enable drives busy on selected pin
// - Alert enable drives alert on selected pin unless busy also selects that pin
// - Input field shows levels of input pins
// - Lead-frame: input bits three to one zero
// - Output field sets output pin levels
// - Temperature enable adds sensor to sequence
// - Function control register resets to zero
// - Pin state register resets to zero
// - Temperature control resets zero, upper reserved
// - Plain pin needs its enable, no higher function
package gpf_pkg;
    localparam int NUM_PINS = 4;
    localparam int REG_W = 8;
    localparam int BUS_W = 32;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PIN_ENABLE = 8'h26;
    localparam logic [7:0] IDX_PIN_FUNCTION_CONTROL = 8'h27;
    localparam logic [7:0] IDX_GENERAL_PIN_STATE = 8'h28;
    localparam logic [7:0] IDX_TEMPERATURE_SENSOR_CONTROL = 8'h29;
    localparam logic [7:0] IDX_EVENT_STATUS = 8'h40;
    localparam logic [7:0] IDX_EVENT_CLEAR = 8'h41;
    localparam logic [7:0] IDX_EVENT_ENABLE = 8'h42;
    localparam int ADDR_LSB = 2;
    localparam int IDX_W = 8;
    // Reset values
    localparam logic [7:0] RST_PIN_ENABLE = 8'h00;
    localparam logic [7:0] RST_FUNCTION = 8'h00;
    localparam logic [7:0] RST_PIN_STATE = 8'h00;
    localparam logic [7:0] RST_TEMP = 8'h00;
    localparam logic [1:0] RST_EVENTS = 2'h0;
    // Pin function control fields
    localparam int BIT_ALERT_REPORT_MODE = 7;
    localparam int BIT_BUSY_PIN_SELECT = 5;
    localparam int BIT_ALERT_PIN_SELECT = 4;
    localparam int LANE_HI = 3;
    localparam int LANE_LO = 2;
    localparam int BIT_BUSY_PIN_ENABLE = 1;
    localparam int BIT_ALERT_PIN_ENABLE = 0;
    localparam logic [7:0] MASK_FUNCTION = 8'hBF;
    localparam logic [1:0] LANE_CODE_SINGLE = 2'h0;
    localparam logic [1:0] LANE_CODE_DUAL = 2'h1;
    localparam logic [1:0] LANE_CODE_PKG = 2'h2;
    localparam logic [1:0] LANE_CODE_ONES = 2'h3;
    // Pin state fields
    localparam int INPUT_LO = 4;
    localparam int OUTPUT_LO = 0;
    // Pin enable fields
    localparam int IN_EN_LO = 4;
    localparam int OUT_EN_LO = 0;
    // Temperature control
    localparam int BIT_TEMP_EN = 0;
    localparam logic [7:0] MASK_TEMP = 8'h01;
    // Pin numbers with fixed alternate functions
    localparam int PIN_SHARED = 0;
    localparam int PIN_ALERT_ALT = 2;
    localparam int PIN_BUSY_ALT = 3;
    // Event bits
    localparam int EV_ALERT_RISE = 0;
    localparam int EV_INPUT_CHANGE = 1;
    localparam int NUM_EVENTS = 2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    typedef enum logic [1:0] {LANE_SINGLE, LANE_DUAL, LANE_QUAD} gpf_lane_t;
    typedef enum logic [2:0] {OWN_NONE, OWN_BUSY, OWN_ALERT, OWN_OUTPUT, OWN_INPUT} gpf_owner_t;
endpackage : gpf_pkg

// [gpf_pin_function.sv]
// General-purpose pin function control with AHB-Lite register slave
`timescale 1ns/100ps
module gpf_pin_function #(
    parameter int NUM_PINS = gpf_pkg::NUM_PINS
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic PKG_WAFER_LEVEL,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    input wire logic BUSY_IND,
    input wire logic THRESHOLD_ALERT_STATE,
    input wire logic OVERVOLTAGE_EVENT,
    output logic OVERVOLTAGE_ALERT_STATUS,
    output logic [NUM_PINS-1:0] SDO_LANE_EN,
    output logic TEMP_SENSOR_IN_SEQ,
    input wire logic [NUM_PINS-1:0] GP_IN,
    output logic [NUM_PINS-1:0] GP_OUT,
    output logic [NUM_PINS-1:0] GP_OE,
    output logic IRQ
);
    logic wafer_reg;
    logic [7:0] pin_enable_reg;
    logic [7:0] function_reg;
    logic [7:0] pin_state_out_reg;
    logic [7:0] temp_reg;
    logic [1:0] ev_status_reg;
    logic [1:0] ev_enable_reg;
    logic [1:0] ev_set;
    logic [1:0] ev_clear;
    logic [NUM_PINS-1:0] gpi_reg;
    logic [NUM_PINS-1:0] gpi_prev_reg;
    logic alert_prev_reg;
    logic wr_pend_reg;
    logic [7:0] wr_idx_reg;
    logic [31:0] hrdata_reg;
    logic [NUM_PINS-1:0] in_level;
    logic [NUM_PINS-1:0] is_input;
    gpf_pkg::gpf_owner_t owner [NUM_PINS];
    gpf_pkg::gpf_lane_t lane;
    logic addr_take;
    logic [7:0] addr_idx;

    // Which function owns pin n; busy above alert above output above input
    function automatic gpf_pkg::gpf_owner_t pin_owner(input int n, input logic wafer,
                                                      input logic [7:0] fn, input logic [7:0] en);
        logic avail;
        logic busy_here;
        logic alert_here;
        avail = (n == gpf_pkg::PIN_SHARED) || wafer;
        busy_here = fn[gpf_pkg::BIT_BUSY_PIN_ENABLE] &&
            ((fn[gpf_pkg::BIT_BUSY_PIN_SELECT] && wafer) ? (n == gpf_pkg::PIN_BUSY_ALT)
                                                         : (n == gpf_pkg::PIN_SHARED));
        alert_here = fn[gpf_pkg::BIT_ALERT_PIN_ENABLE] &&
            ((fn[gpf_pkg::BIT_ALERT_PIN_SELECT] && wafer) ? (n == gpf_pkg::PIN_ALERT_ALT)
                                                          : (n == gpf_pkg::PIN_SHARED));
        if (busy_here) begin
            pin_owner = gpf_pkg::OWN_BUSY;
        end else if (alert_here) begin
            pin_owner = gpf_pkg::OWN_ALERT;
        // plain functions only when enabled and nothing higher
        end else if (avail && en[gpf_pkg::OUT_EN_LO + n]) begin
            pin_owner = gpf_pkg::OWN_OUTPUT;
        end else if (avail && en[gpf_pkg::IN_EN_LO + n]) begin
            pin_owner = gpf_pkg::OWN_INPUT;
        end else begin
            pin_owner = gpf_pkg::OWN_NONE;
        end
    endfunction : pin_owner

    // Index of a byte address; address bits 1:0 are ignored
    function automatic logic [7:0] addr_to_idx(input logic [31:0] a);
        addr_to_idx = a[gpf_pkg::ADDR_LSB +: gpf_pkg::IDX_W];
    endfunction : addr_to_idx

    // Package variant caught while reset is held
    always_ff @(posedge MCLK) begin
        if (RST) begin
            wafer_reg <= PKG_WAFER_LEVEL;
        end
    end

    // Zero wait states; CE low stalls the bus rather than drop a transfer
    assign HREADYOUT = CE;
    assign HRESP = 1'b0;
    assign HRDATA = hrdata_reg;
    assign addr_take = CE && HSEL && HREADY && (HTRANS == gpf_pkg::HTRANS_NONSEQ);
    assign addr_idx = addr_to_idx(HADDR);

    always_ff @(posedge MCLK) begin
        if (RST) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 8'h00;
        end else if (CE) begin
            wr_pend_reg <= addr_take && HWRITE;
            wr_idx_reg <= addr_idx;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            function_reg <= gpf_pkg::RST_FUNCTION;
        end else if (CE && wr_pend_reg && wr_idx_reg == gpf_pkg::IDX_PIN_FUNCTION_CONTROL) begin
            function_reg <= HWDATA[7:0] & gpf_pkg::MASK_FUNCTION;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            pin_enable_reg <= gpf_pkg::RST_PIN_ENABLE;
        end else if (CE && wr_pend_reg && wr_idx_reg == gpf_pkg::IDX_PIN_ENABLE) begin
            pin_enable_reg <= HWDATA[7:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            pin_state_out_reg <= gpf_pkg::RST_PIN_STATE;
        end else if (CE && wr_pend_reg && wr_idx_reg == gpf_pkg::IDX_GENERAL_PIN_STATE) begin
            pin_state_out_reg <= {4'h0, HWDATA[3:1] & {3{wafer_reg}}, HWDATA[gpf_pkg::OUTPUT_LO]};
        end
    end

    // temperature control, upper bits read only
    always_ff @(posedge MCLK) begin
        if (RST) begin
            temp_reg <= gpf_pkg::RST_TEMP;
        end else if (CE && wr_pend_reg && wr_idx_reg == gpf_pkg::IDX_TEMPERATURE_SENSOR_CONTROL) begin
            temp_reg <= HWDATA[7:0] & gpf_pkg::MASK_TEMP;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            ev_enable_reg <= gpf_pkg::RST_EVENTS;
        end else if (CE && wr_pend_reg && wr_idx_reg == gpf_pkg::IDX_EVENT_ENABLE) begin
            ev_enable_reg <= HWDATA[gpf_pkg::NUM_EVENTS-1:0];
        end
    end

    // Pin ownership and input view per pin
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            assign owner[gi] = pin_owner(gi, wafer_reg, function_reg, pin_enable_reg);
            assign is_input[gi] = (owner[gi] == gpf_pkg::OWN_INPUT);
            // only input pins report a level
            // lead-frame leaves pins above zero unavailable
            assign in_level[gi] = is_input[gi] && gpi_reg[gi];

            always_ff @(posedge MCLK) begin
                if (RST) begin
                    GP_OUT[gi] <= 1'b0;
                    GP_OE[gi] <= 1'b0;
                end else if (CE) begin
                    case (owner[gi])
                        gpf_pkg::OWN_BUSY: begin
                            GP_OUT[gi] <= BUSY_IND;
                            GP_OE[gi] <= 1'b1;
                        end
                        gpf_pkg::OWN_ALERT: begin
                            GP_OUT[gi] <= THRESHOLD_ALERT_STATE;
                            GP_OE[gi] <= 1'b1;
                        end
                        gpf_pkg::OWN_OUTPUT: begin
                            GP_OUT[gi] <= pin_state_out_reg[gpf_pkg::OUTPUT_LO + gi];
                            GP_OE[gi] <= 1'b1;
                        end
                        default: begin
                            GP_OUT[gi] <= 1'b0;
                            GP_OE[gi] <= 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

    always_ff @(posedge MCLK) begin
        if (RST) begin
            gpi_reg <= '0;
            gpi_prev_reg <= '0;
            alert_prev_reg <= 1'b0;
        end else if (CE) begin
            gpi_reg <= GP_IN;
            gpi_prev_reg <= in_level;
            alert_prev_reg <= THRESHOLD_ALERT_STATE;
        end
    end

    // Lane mode decode
    always_comb begin
        case (function_reg[gpf_pkg::LANE_HI:gpf_pkg::LANE_LO])
            gpf_pkg::LANE_CODE_SINGLE: lane = gpf_pkg::LANE_SINGLE;
            gpf_pkg::LANE_CODE_DUAL: lane = gpf_pkg::LANE_DUAL;
            gpf_pkg::LANE_CODE_PKG: lane = wafer_reg ? gpf_pkg::LANE_QUAD : gpf_pkg::LANE_SINGLE;
            default: lane = gpf_pkg::LANE_SINGLE;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            SDO_LANE_EN <= '0;
            OVERVOLTAGE_ALERT_STATUS <= 1'b0;
            TEMP_SENSOR_IN_SEQ <= 1'b0;
        end else if (CE) begin
            case (lane)
                gpf_pkg::LANE_QUAD: SDO_LANE_EN <= '1;
                gpf_pkg::LANE_DUAL: SDO_LANE_EN <= NUM_PINS'(2'h3);
                default: SDO_LANE_EN <= NUM_PINS'(1'b1);
            endcase
            // status carries alert only in report mode
            OVERVOLTAGE_ALERT_STATUS <= function_reg[gpf_pkg::BIT_ALERT_REPORT_MODE] ?
                                        THRESHOLD_ALERT_STATE : OVERVOLTAGE_EVENT;
            TEMP_SENSOR_IN_SEQ <= temp_reg[gpf_pkg::BIT_TEMP_EN];
        end
    end

    // Sticky events; a new event beats a clear in the same cycle
    always_comb begin
        ev_set = '0;
        ev_set[gpf_pkg::EV_ALERT_RISE] = THRESHOLD_ALERT_STATE && !alert_prev_reg;
        ev_set[gpf_pkg::EV_INPUT_CHANGE] = |(in_level ^ gpi_prev_reg);
        ev_clear = (CE && wr_pend_reg && wr_idx_reg == gpf_pkg::IDX_EVENT_CLEAR) ?
                   HWDATA[gpf_pkg::NUM_EVENTS-1:0] : 2'h0;
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            ev_status_reg <= gpf_pkg::RST_EVENTS;
        end else if (CE) begin
            ev_status_reg <= (ev_status_reg & ~ev_clear) | ev_set;
        end
    end

    assign IRQ = |(ev_status_reg & ev_enable_reg);

    // Read data captured in the address phase
    always_ff @(posedge MCLK) begin
        if (RST) begin
            hrdata_reg <= '0;
        end else if (CE) begin
            hrdata_reg <= '0;
            if (addr_take && !HWRITE) begin
                if (HADDR[1:0] != 2'h0) begin
                    hrdata_reg <= '0;
                end else if (addr_idx == gpf_pkg::IDX_PIN_ENABLE) begin
                    hrdata_reg <= {24'h0, pin_enable_reg};
                end else if (addr_idx == gpf_pkg::IDX_PIN_FUNCTION_CONTROL) begin
                    hrdata_reg <= {24'h0, function_reg};
                end else if (addr_idx == gpf_pkg::IDX_GENERAL_PIN_STATE) begin
                    hrdata_reg <= {24'h0, in_level, pin_state_out_reg[3:0]};
                end else if (addr_idx == gpf_pkg::IDX_TEMPERATURE_SENSOR_CONTROL) begin
                    hrdata_reg <= {24'h0, temp_reg};
                end else if (addr_idx == gpf_pkg::IDX_EVENT_STATUS) begin
                    hrdata_reg <= {30'h0, ev_status_reg};
                end else if (addr_idx == gpf_pkg::IDX_EVENT_ENABLE) begin
                    hrdata_reg <= {30'h0, ev_enable_reg};
                end
            end
        end
    end
endmodule : gpf_pin_function

// [gpf_monitor.sv]
// Assertion checker for the pin function control block
`timescale 1ns/100ps
module gpf_monitor #(
    parameter int NUM_PINS = 4
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic PKG_WAFER_LEVEL,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic THRESHOLD_ALERT_STATE,
    input wire logic OVERVOLTAGE_EVENT,
    input wire logic OVERVOLTAGE_ALERT_STATUS,
    input wire logic [NUM_PINS-1:0] SDO_LANE_EN,
    input wire logic TEMP_SENSOR_IN_SEQ,
    input wire logic [NUM_PINS-1:0] GP_OUT,
    input wire logic [NUM_PINS-1:0] GP_OE,
    input wire logic IRQ
);
    logic taken;
    logic rd_dp;
    logic wr_temp;
    logic wafer;
    assign taken = CE && HSEL && HREADY && HTRANS == gpf_pkg::HTRANS_NONSEQ;
    // Strap copy, taken like the design only while in reset
    always_ff @(posedge MCLK) begin
        if (RST) begin
            rd_dp <= 1'b0;
            wr_temp <= 1'b0;
            wafer <= PKG_WAFER_LEVEL;
        end else begin
            rd_dp <= taken && !HWRITE;
            wr_temp <= taken && HWRITE && HADDR == {22'h0, gpf_pkg::IDX_TEMPERATURE_SENSOR_CONTROL, 2'h0};
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    AST_RDATA_UPPER: assert property (HRDATA[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    AST_RDATA_IDLE: assert property (!rd_dp |-> HRDATA == 32'h0)
        else $error("read data outside read data phase");
    AST_LANE_CODE: assert property (!$past(RST) |-> SDO_LANE_EN inside {4'h1, 4'h3, 4'hF})
        else $error("illegal lane enable pattern");
    AST_LEAD_NO_QUAD: assert property (!wafer && !$past(RST) |-> SDO_LANE_EN != 4'hF)
        else $error("quad lanes on lead-frame part");
    AST_LEAD_PINS: assert property (!wafer |-> GP_OE[3:1] == 3'h0)
        else $error("upper pins driven on lead-frame part");
    AST_STATUS_SRC: assert property (!$past(RST) |-> OVERVOLTAGE_ALERT_STATUS == $past(THRESHOLD_ALERT_STATE)
        || OVERVOLTAGE_ALERT_STATUS == $past(OVERVOLTAGE_EVENT))
        else $error("status bit from no source");
    AST_TEMP_CAUSE: assert property (!$stable(TEMP_SENSOR_IN_SEQ) |-> wr_temp || $past(wr_temp) || $past(wr_temp, 2))
        else $error("temperature enable moved without a write");
    AST_RESET_OUTS: assert property ($past(RST) |-> GP_OUT == 4'h0 && GP_OE == 4'h0 && SDO_LANE_EN == 4'h0
        && !TEMP_SENSOR_IN_SEQ && !IRQ)
        else $error("outputs not cleared by reset");
    COV_QUAD: cover property (SDO_LANE_EN == 4'hF);
    COV_IRQ: cover property (IRQ);
    COV_READ: cover property (rd_dp && HRDATA != 32'h0);
endmodule : gpf_monitor
bind gpf_pin_function gpf_monitor #(.NUM_PINS(NUM_PINS)) u_mon (.MCLK(MCLK), .RST(RST), .CE(CE),
    .PKG_WAFER_LEVEL(PKG_WAFER_LEVEL), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HREADY(HREADY), .HRDATA(HRDATA), .THRESHOLD_ALERT_STATE(THRESHOLD_ALERT_STATE),
    .OVERVOLTAGE_EVENT(OVERVOLTAGE_EVENT), .OVERVOLTAGE_ALERT_STATUS(OVERVOLTAGE_ALERT_STATUS),
    .SDO_LANE_EN(SDO_LANE_EN), .TEMP_SENSOR_IN_SEQ(TEMP_SENSOR_IN_SEQ), .GP_OUT(GP_OUT), .GP_OE(GP_OE), .IRQ(IRQ));

// [gpf_host_model.sv]
// Host side model: counts data lanes, drives undriven pins
`timescale 1ns/100ps
module gpf_host_model (
    input wire logic [3:0] SDO_LANE_EN,
    input wire logic [3:0] GP_OUT,
    input wire logic [3:0] GP_OE,
    input wire logic [3:0] drive_val,
    output logic [3:0] GP_IN,
    output logic [2:0] lanes
);
    // Driven pins read back the device level
    assign GP_IN = (GP_OE & GP_OUT) | (~GP_OE & drive_val);
    assign lanes = 3'(SDO_LANE_EN[0]) + 3'(SDO_LANE_EN[1]) + 3'(SDO_LANE_EN[2]) + 3'(SDO_LANE_EN[3]);
endmodule : gpf_host_model

// [tb_top.sv]
// Self-checking testbench for the pin function control block
`timescale 1ns/100ps
module tb_top;
    localparam logic [31:0] A_EN = 32'(gpf_pkg::IDX_PIN_ENABLE) << 2;
    localparam logic [31:0] A_FN = 32'(gpf_pkg::IDX_PIN_FUNCTION_CONTROL) << 2;
    localparam logic [31:0] A_ST = 32'(gpf_pkg::IDX_GENERAL_PIN_STATE) << 2;
    localparam logic [31:0] A_TMP = 32'(gpf_pkg::IDX_TEMPERATURE_SENSOR_CONTROL) << 2;
    localparam logic [31:0] A_IS = 32'(gpf_pkg::IDX_EVENT_STATUS) << 2;
    localparam logic [31:0] A_IC = 32'(gpf_pkg::IDX_EVENT_CLEAR) << 2;
    localparam logic [31:0] A_IE = 32'(gpf_pkg::IDX_EVENT_ENABLE) << 2;
    logic MCLK = 1'b0;
    logic RST = 1'b1;
    logic pkg = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic busy = 1'b0;
    logic thr = 1'b0;
    logic ove = 1'b0;
    logic [3:0] drv = 4'h0;
    logic hreadyout, hresp, ovs, temp_seq, irq;
    logic [31:0] hrdata;
    logic [3:0] lane_en, gp_in, gp_out, gp_oe;
    logic [2:0] lanes;
    int n_fail = 0;
    int n_tests = 0;
    initial begin
        forever #10 MCLK = ~MCLK;
    end
    gpf_pin_function u_dut (.MCLK(MCLK), .RST(RST), .CE(1'b1), .PKG_WAFER_LEVEL(pkg), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(gpf_pkg::HSIZE_WORD), .HWDATA(hwdata),
        .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .BUSY_IND(busy),
        .THRESHOLD_ALERT_STATE(thr), .OVERVOLTAGE_EVENT(ove), .OVERVOLTAGE_ALERT_STATUS(ovs),
        .SDO_LANE_EN(lane_en), .TEMP_SENSOR_IN_SEQ(temp_seq), .GP_IN(gp_in), .GP_OUT(gp_out),
        .GP_OE(gp_oe), .IRQ(irq));
    gpf_host_model u_host (.SDO_LANE_EN(lane_en), .GP_OUT(gp_out), .GP_OE(gp_oe), .drive_val(drv),
        .GP_IN(gp_in), .lanes(lanes));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= gpf_pkg::HTRANS_NONSEQ;
        do @(posedge MCLK); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge MCLK); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask : rd
    // Register to pin takes one edge, sampled two edges later
    task automatic settle;
        repeat (3) @(posedge MCLK);
    endtask : settle
    task automatic do_reset(input logic w);
        RST <= 1'b1;
        pkg <= w;
        repeat (5) @(posedge MCLK);
        RST <= 1'b0;
        @(posedge MCLK);
    endtask : do_reset
    task automatic t_regs;
        rd(A_FN, 32'h0);
        rd(A_ST, 32'h0);
        rd(A_TMP, 32'h0);
        wr(A_TMP, 32'hFF);
        rd(A_TMP, 32'h1);
        settle;
        chk(32'(temp_seq), 32'h1);
        wr(A_FN, 32'hFF);
        rd(A_FN, 32'hBF);
        rd(32'h200, 32'h0);
        wr(A_FN, 32'h0);
        wr(A_TMP, 32'h0);
        settle;
        chk(32'(temp_seq), 32'h0);
    endtask : t_regs
    task automatic t_lanes(input logic w);
        logic [2:0] exp [4];
        exp = '{3'h1, 3'h2, w ? 3'h4 : 3'h1, 3'h1};
        for (int c = 0; c < 4; c++) begin
            wr(A_FN, 32'(c) << 2);
            settle;
            chk(32'(lanes), 32'(exp[c]));
        end
    endtask : t_lanes
    task automatic t_pins(input logic w);
        busy <= 1'b1;
        wr(A_FN, 32'h02);
        settle;
        chk(32'(gp_oe & gp_out), 32'h1);
        wr(A_FN, 32'h22);
        settle;
        chk(32'(gp_oe & gp_out), w ? 32'h8 : 32'h1);
        wr(A_FN, 32'h11);
        settle;
        chk(32'(gp_oe), w ? 32'h4 : 32'h1);
        wr(A_FN, 32'h0);
        busy <= 1'b0;
    endtask : t_pins
    task automatic t_gpio(input logic w);
        wr(A_EN, 32'h0F);
        wr(A_ST, 32'hFB);
        rd(A_ST, w ? 32'h0B : 32'h01);
        settle;
        chk(32'(gp_oe & gp_out), w ? 32'hB : 32'h1);
        drv <= 4'h5;
        wr(A_EN, 32'hF0);
        settle;
        rd(A_ST, w ? 32'h5B : 32'h11);
        wr(A_EN, 32'h0);
        wr(A_ST, 32'h0);
    endtask : t_gpio
    task automatic t_status;
        thr <= 1'b1;
        wr(A_FN, 32'h80);
        settle;
        chk(32'(ovs), 32'h1);
        wr(A_FN, 32'h0);
        settle;
        chk(32'(ovs), 32'h0);
        ove <= 1'b1;
        settle;
        chk(32'(ovs), 32'h1);
        ove <= 1'b0;
        thr <= 1'b0;
    endtask : t_status
    // Alert rise sets the event; mask and clear must drop the line
    task automatic t_irq;
        wr(A_IE, 32'h1);
        wr(A_IC, 32'h3);
        thr <= 1'b1;
        settle;
        chk(32'(irq), 32'h1);
        rd(A_IS, 32'h1);
        // Write lands on the edge the task returns at; look one edge later
        wr(A_IE, 32'h0);
        @(posedge MCLK);
        chk(32'(irq), 32'h0);
        wr(A_IE, 32'h1);
        @(posedge MCLK);
        chk(32'(irq), 32'h1);
        wr(A_IC, 32'h1);
        @(posedge MCLK);
        chk(32'(irq), 32'h0);
        rd(A_IS, 32'h0);
        rd(A_IC, 32'h0);
        thr <= 1'b0;
    endtask : t_irq
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (6000) @(posedge MCLK);
        n_fail++;
        stop_test;
    end
    initial begin
        do_reset(1'b1);
        t_regs;
        t_lanes(1'b1);
        t_pins(1'b1);
        t_gpio(1'b1);
        t_status;
        t_irq;
        do_reset(1'b0);
        t_lanes(1'b0);
        t_pins(1'b0);
        t_gpio(1'b0);
        stop_test;
    end
endmodule : tb_top
